//--- src/bitbr_pkg.sv
// Constants and encodings for the bit-operation and relative-branch executor.
// Assumes a 14-bit instruction word, 8-bit file registers and an 8-bit accumulator.
// Operation
// - Bit clear forces bit b of register f to zero, flags untouched.
// - Bit set forces bit b of register f to one, flags untouched.
// - Test skip if zero: bit zero discards next instruction as no-operation.
// - Test skip if one: bit one discards next instruction as no-operation.
// - Literal branch: incremented PC plus sign-extended 9-bit offset, no flag change.
// - Literal branch takes two cycles, flushing the fetched next instruction.
// - Accumulator branch adds unsigned accumulator to incremented PC, two cycles.
package bitbr_pkg;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int OFS_W = 9;
  // Opcode field positions
  localparam int BITOP_LSB = 10;
  localparam int BITOP_W = 4;
  localparam int BRA_LSB = 9;
  localparam int BRA_OP_W = 5;
  localparam int BSEL_LSB = 7;
  // Opcode values
  localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OP_BIT_SET = 4'h5;
  localparam logic [3:0] OP_TEST_ZERO = 4'h6;
  localparam logic [3:0] OP_TEST_ONE = 4'h7;
  localparam logic [4:0] OP_LIT_BRANCH = 5'h19;
  localparam logic [13:0] OP_ACC_BRANCH = 14'h000B;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_ONE = 15'h0001;
  typedef enum logic [1:0] {
    EXEC_RUN = 2'b01,
    EXEC_FLUSH = 2'b10
  } exec_state_t;
endpackage : bitbr_pkg

//--- src/bit_modify.sv
// Single-bit modify unit: clears or sets one selected bit of a data byte.
// Assumes the caller supplies the byte already read from the file register.
`timescale 1ns/1ps
module bit_modify #(
  parameter int DW = 8
) (
  input wire logic [DW-1:0] data_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic set_i,
  output logic [DW-1:0] data_o
);
  wire logic [DW-1:0] mask = DW'(1) << bit_sel_i;
  assign data_o = set_i ? (data_i | mask) : (data_i & ~mask);
endmodule : bit_modify

//--- src/bit_branch_exec.sv
// Executes bit clear/set, bit test skips and the two relative branches.
// Assumes one instruction per clock and file read data valid combinationally.
`timescale 1ns/1ps
module bit_branch_exec #(
  parameter int PC_WIDTH = bitbr_pkg::PC_W
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [bitbr_pkg::INSTR_W-1:0] instr_i,
  input wire logic [bitbr_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic [bitbr_pkg::DATA_W-1:0] acc_i,
  output logic [bitbr_pkg::FADDR_W-1:0] file_addr_o,
  output logic [bitbr_pkg::DATA_W-1:0] file_wdata_o,
  output logic file_we_o,
  output logic [PC_WIDTH-1:0] pc_o,
  output logic pc_load_o,
  output logic flush_o,
  output logic [bitbr_pkg::INSTR_W-1:0] exec_instr_o,
  output logic status_we_o
);
  // ==========================================================
  // Decode
  bitbr_pkg::exec_state_t state;
  bitbr_pkg::exec_state_t next_state;
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] next_pc;
  wire logic [3:0] bitop = instr_i[bitbr_pkg::BITOP_LSB +: bitbr_pkg::BITOP_W];
  wire logic [4:0] braop = instr_i[bitbr_pkg::BRA_LSB +: bitbr_pkg::BRA_OP_W];
  wire logic [2:0] bsel = instr_i[bitbr_pkg::BSEL_LSB +: bitbr_pkg::BIT_W];
  wire logic [6:0] faddr = instr_i[bitbr_pkg::FADDR_W-1:0];
  wire logic [8:0] ofs = instr_i[bitbr_pkg::OFS_W-1:0];
  wire logic run = instr_valid_i && (state == bitbr_pkg::EXEC_RUN);

  // Bit-group decode, shared by all four bit instructions
  function automatic logic bit_group(input logic en, input logic [3:0] op,
                                     input logic [3:0] code);
    return en && (op == code);
  endfunction : bit_group

  wire logic is_clr = bit_group(run, bitop, bitbr_pkg::OP_BIT_CLEAR);
  wire logic is_set = bit_group(run, bitop, bitbr_pkg::OP_BIT_SET);
  wire logic is_tz = bit_group(run, bitop, bitbr_pkg::OP_TEST_ZERO);
  wire logic is_to = bit_group(run, bitop, bitbr_pkg::OP_TEST_ONE);
  wire logic is_lbr = run && (braop == bitbr_pkg::OP_LIT_BRANCH);
  wire logic is_abr = run && (instr_i == bitbr_pkg::OP_ACC_BRANCH);
  wire logic sel_bit = file_rdata_i[bsel];
  // ==========================================================
  // Skip and branch targets
  // Skip on zero
  wire logic skip_zero = is_tz && !sel_bit;
  wire logic skip_one = is_to && sel_bit;
  // pc already holds the incremented address of the next instruction
  // Sign-extended literal
  wire logic [PC_WIDTH-1:0] lit_target = pc + PC_WIDTH'($signed(ofs));
  wire logic [PC_WIDTH-1:0] acc_target = pc + PC_WIDTH'(acc_i);
  wire logic take = is_lbr || is_abr;
  wire logic discard = take || skip_zero || skip_one;
  wire logic [PC_WIDTH-1:0] inc_pc = pc + PC_WIDTH'(bitbr_pkg::PC_ONE);
  wire logic [bitbr_pkg::DATA_W-1:0] mod_data;
  // ==========================================================
  // Bit modify
  // Clear and set path
  bit_modify #(
    .DW(bitbr_pkg::DATA_W)
  ) u_mod (
    .data_i(file_rdata_i),
    .bit_sel_i(bsel),
    .set_i(is_set),
    .data_o(mod_data)
  );
  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      bitbr_pkg::EXEC_RUN: begin
        if (discard) begin
          next_state = bitbr_pkg::EXEC_FLUSH;
        end
      end
      bitbr_pkg::EXEC_FLUSH: begin
        // Flush lasts exactly one cycle
        next_state = bitbr_pkg::EXEC_RUN;
      end
      default: begin
        next_state = bitbr_pkg::EXEC_RUN;
      end
    endcase
  end

  // ==========================================================
  // Next program counter
  // Idle cycles in EXEC_RUN hold pc, so a stalled fetch never loses its place
  always_comb begin
    next_pc = pc;
    case (state)
      bitbr_pkg::EXEC_RUN: begin
        if (instr_valid_i) begin
          next_pc = is_lbr ? lit_target : (is_abr ? acc_target : inc_pc);
        end
      end
      bitbr_pkg::EXEC_FLUSH: begin
        next_pc = inc_pc;
      end
      default: begin
        next_pc = pc;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= bitbr_pkg::EXEC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Program counter register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc <= PC_WIDTH'(bitbr_pkg::PC_RESET);
    end else begin
      pc <= next_pc;
    end
  end

  // ==========================================================
  // Registered outputs
  // Registered, so write and flush appear one cycle after decode
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_addr_o <= '0;
    end else begin
      file_addr_o <= faddr;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_wdata_o <= '0;
    end else begin
      file_wdata_o <= mod_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= is_clr || is_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_o <= PC_WIDTH'(bitbr_pkg::PC_RESET);
    end else begin
      pc_o <= next_pc;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= take;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= discard;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_instr_o <= bitbr_pkg::NOP_WORD;
    end else begin
      exec_instr_o <= (state == bitbr_pkg::EXEC_FLUSH) ? bitbr_pkg::NOP_WORD : instr_i;
    end
  end

  // Flags never written
  // None of these six instructions touches status, so the strobe is tied low
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_we_o <= 1'b0;
    end else begin
      status_we_o <= 1'b0;
    end
  end
endmodule : bit_branch_exec

//--- test/bbx_sva.sv
// Checker on the executor's top ports.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module bbx_sva #(parameter int PC_WIDTH = 15) (
  input wire logic ref_clk_i, rstn_i, instr_valid_i, flush_o, pc_load_o, file_we_o, status_we_o,
  input wire logic [13:0] instr_i, exec_instr_o,
  input wire logic [7:0] file_rdata_i, acc_i, file_wdata_o,
  input wire logic [PC_WIDTH-1:0] pc_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Words in the flush cycle are not taken
  wire tk = instr_valid_i && !flush_o;
  wire [3:0] op = instr_i[13:10];
  wire bv = file_rdata_i[instr_i[9:7]];
  wire lit = tk && instr_i[13:9] == 5'h19;
  a_clear_bit: assert property (tk && op == 4'h4 |=>
    file_we_o && !file_wdata_o[$past(instr_i[9:7])]) else $error("bit clear wrong");
  a_set_bit: assert property (tk && op == 4'h5 |=>
    file_we_o && file_wdata_o[$past(instr_i[9:7])]) else $error("bit set wrong");
  a_skip_zero: assert property (tk && op == 4'h6 |=> flush_o == !$past(bv))
    else $error("skip if zero wrong");
  a_skip_one: assert property (tk && op == 4'h7 |=> flush_o == $past(bv))
    else $error("skip if one wrong");
  a_lit_target: assert property (lit |=> pc_load_o && pc_o ==
    $past(PC_WIDTH'(pc_o + PC_WIDTH'($signed(instr_i[8:0]))))) else $error("branch target");
  a_lit_flush: assert property (lit |=> flush_o ##1 exec_instr_o == 14'h0000)
    else $error("branch not two cycles");
  a_acc_target: assert property (tk && instr_i == 14'h000b |=> pc_load_o && flush_o &&
    pc_o == $past(PC_WIDTH'(pc_o + acc_i))) else $error("acc branch wrong");
  a_flush_once: assert property (flush_o |=> !flush_o && exec_instr_o == 14'h0000)
    else $error("flush not one cycle");
  a_no_flags: assert property (!status_we_o) else $error("flag write");
  c_skip: cover property (tk && op == 4'h6 ##1 flush_o);
  c_load: cover property (pc_load_o);
  c_write: cover property (file_we_o);
endmodule : bbx_sva
bind bit_branch_exec bbx_sva #(.PC_WIDTH(PC_WIDTH)) i_sva (.*);

//--- test/regfile_model.sv
// File register model beside the executor.
// Assumes reads follow the f field of the word on the bus.
`timescale 1ns/1ps
module regfile_model (
  input wire logic ref_clk_i, we_i,
  input wire logic [6:0] raddr_i, waddr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o);
  logic [7:0] mem [128] = '{default: 8'ha5};
  assign rdata_o = mem[raddr_i];
  always @(posedge ref_clk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule : regfile_model

//--- test/bit_ops_and_relative_branch_exec_tb.sv
// Bench for the executor with a file register model.
// Assumes outputs settle one cycle after a word is taken.
`timescale 1ns/1ps
module bit_ops_and_relative_branch_exec_tb;
  logic ref_clk_i = 0, rstn_i = 0, instr_valid_i = 0;
  logic [13:0] instr_i = 14'h0000, exec_instr_o;
  logic [7:0] file_rdata_i, acc_i = 8'hff, file_wdata_o;
  logic [6:0] file_addr_o;
  logic [14:0] pc_o, pc0;
  logic file_we_o, pc_load_o, flush_o, status_we_o;
  int err_count = 0, check_count = 0, cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  bit_branch_exec i_dut (.*);
  regfile_model i_rf (.ref_clk_i, .we_i(file_we_o), .raddr_i(instr_i[6:0]),
    .waddr_i(file_addr_o), .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
  task automatic chk(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input logic [13:0] w);
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    #1 pc0 = pc_o;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1 chk(exec_instr_o, w);
  endtask : go
  task automatic t_bits;
    go({4'h5, 3'h1, 7'h05});
    go({4'h4, 3'h7, 7'h06});
    @(posedge ref_clk_i);
    #1 chk(i_rf.mem[5], 8'ha7);
    chk(i_rf.mem[6], 8'h25);
    chk(status_we_o, 1'b0);
  endtask : t_bits
  task automatic t_skip;
    // Reg 5 holds a7: bit 0 one, bit 6 zero
    for (int i = 0; i < 4; i++) begin
      go({3'h3, i[0], i[1] ? 3'h6 : 3'h0, 7'h05});
      chk(flush_o, i[0] ^ i[1]);
    end
  endtask : t_skip
  task automatic t_branch;
    // pc already holds the incremented address, so the offset adds directly
    go({5'h19, 9'h0ff});
    chk(pc_o, pc0 + 15'h00ff);
    chk(flush_o & pc_load_o, 1'b1);
    go(14'h000b);
    chk(pc_o, pc0 + 15'h00ff);
    go({5'h19, 9'h100});
    chk(pc_o, pc0 - 15'h0100);
    @(posedge ref_clk_i);
    #1 chk(exec_instr_o, 14'h0000);
  endtask : t_branch
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // ==========
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 500) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_bits();
    t_skip();
    t_branch();
    test_done();
  end
endmodule : bit_ops_and_relative_branch_exec_tb
